// File: hw/scs_pkg.sv
package scs_pkg;

    // Byte offsets of the control_status_port words
    localparam logic [4:0] OFF_STATUS = 5'h00;
    localparam logic [4:0] OFF_CONTROL = 5'h04;
    localparam logic [4:0] OFF_CMD_FILL = 5'h08;
    localparam logic [4:0] OFF_RSP_FILL = 5'h0C;
    localparam logic [4:0] OFF_SEQ_NUM = 5'h10;
    localparam logic [4:0] OFF_CONFIG_ONE = 5'h14;
    localparam logic [4:0] OFF_CONFIG_TWO = 5'h18;
    localparam logic [4:0] OFF_IDENTITY = 5'h1C;

    // engine_status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_CMD_EMPTY = 1;
    localparam int ST_CMD_FULL = 2;
    localparam int ST_RSP_EMPTY = 3;
    localparam int ST_RSP_FULL = 4;
    localparam int ST_STOPPED = 5;
    localparam int ST_RESETTING = 6;
    localparam int ST_ERR_STOP = 7;
    localparam int ST_EARLY_STOP = 8;
    localparam int ST_IRQ = 9;

    // engine_control bit positions
    localparam int CT_STOP = 0;
    localparam int CT_RESET = 1;
    localparam int CT_STOP_ERR = 2;
    localparam int CT_STOP_EARLY = 3;
    localparam int CT_IRQ_MASK = 4;
    localparam int CT_STOP_DESC = 5;
    localparam int CTL_WIDTH = 6;
    localparam logic [5:0] CTL_RESET_VALUE = 6'h00;

    // Sticky flag indices
    localparam int FL_IRQ = 0;
    localparam int FL_ERR = 1;
    localparam int FL_EARLY = 2;
    localparam int FL_COUNT = 3;

    localparam logic [3:0] RESET_HOLD_CYCLES = 4'h2;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_HOLD = 2'b01,
        RS_DRAIN = 2'b10
    } scs_rst_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] addr;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } scs_csr_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic readdatavalid;
    } scs_csr_rsp_t;

    typedef struct packed {
        logic [15:0] wr_cmd_fill;
        logic [15:0] rd_cmd_fill;
        logic wr_cmd_full;
        logic rd_cmd_full;
        logic wr_cmd_empty;
        logic rd_cmd_empty;
        logic [15:0] rsp_fill;
        logic rsp_full;
        logic rsp_empty;
        logic [15:0] wr_seq;
        logic [15:0] rd_seq;
        logic rd_active;
        logic wr_active;
        logic wr_rsp_wait;
        logic error_beat;
        logic early_term;
        logic irq_event;
        logic fabric_drained;
    } scs_engine_obs_t;

    typedef struct packed {
        logic [CTL_WIDTH-1:0] control;
        logic dispatcher_reset;
        logic issue_halt;
        logic irq_pending;
    } scs_engine_ctl_t;

endpackage : scs_pkg

// File: hw/scs_flag_bit.sv
`timescale 1ns/1ps
module scs_flag_bit (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic set,
    input wire logic clear,
    output logic q
);
    import scs_pkg::*;

    typedef struct packed {
        logic q;
    } scs_flag_state_t;

    scs_flag_state_t st;
    scs_flag_state_t next_st;

    always_comb begin
        next_st = st;
        // Set beats clear so an event in the clearing cycle survives
        if (set) begin
            next_st.q = 1'b1; // R6
        end else if (clear) begin
            next_st.q = 1'b0; // R5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

    set_wins_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
        set |=> q)
        else $error("flag lost a set event");
    clear_works_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
        clear && !set |=> !q)
        else $error("flag ignored a clear");

endmodule : scs_flag_bit

// File: hw/scs_reset_seq.sv
`timescale 1ns/1ps
module scs_reset_seq (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic drained,
    output logic resetting
);
    import scs_pkg::*;

    typedef struct packed {
        scs_rst_state_t state;
        logic [3:0] count;
        logic resetting;
    } scs_rst_seq_t;

    scs_rst_seq_t st;
    scs_rst_seq_t next_st;

    always_comb begin
        next_st = st;
        case (st.state)
            RS_IDLE: begin
                if (start) begin
                    next_st.state = RS_HOLD;
                    next_st.count = RESET_HOLD_CYCLES;
                    next_st.resetting = 1'b1; // R10
                end
            end
            RS_HOLD: begin
                // Give the movers a few cycles to see the reset first
                next_st.count = st.count - 4'h1;
                if (st.count == 4'h1) begin
                    next_st.state = RS_DRAIN;
                end
            end
            RS_DRAIN: begin
                // Stay until nothing is in flight on the fabric
                if (drained) begin
                    next_st.state = RS_IDLE;
                    next_st.resetting = 1'b0; // R10
                end
            end
            default: begin
                next_st.state = RS_IDLE;
                next_st.resetting = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign resetting = st.resetting;

    reset_starts_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
        st.state == RS_IDLE && start |=> resetting [*3])
        else $error("resetting did not hold through the hold phase");
    drain_holds_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
        st.state == RS_DRAIN && !drained |=> resetting)
        else $error("resetting dropped before fabric drained");
    reset_done_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $fell(resetting));

endmodule : scs_reset_seq

// File: hw/scs_csr_bank.sv
`timescale 1ns/1ps
// Contract
// [R1] Control/status words on a memory-mapped port at word offsets 0x0 to 0x1C.
// [R2] Offset 0x8 returns write fill level high, read fill level low.
// [R3] Sequence numbers at 0x10 are present only with enhanced features built in.
// [R4] Writes to reserved bits change nothing; their reads are undefined.
// [R5] Interrupt-pending bit 9 set by hardware, cleared by writing one.
// [R6] Set event wins over a same-cycle write-one clear of bit 9.
// [R7] Bit 8 set on length reached without packet end, when enabled.
// [R8] Software wanting no early termination programs length as all ones.
// [R9] Bit 7 set on an error beat at the sink, when enabled.
// [R10] Bit 6 high from software reset request until fabric transfers drain.
// [R11] Software issues no new work while resetting is high.
// [R12] Bit 5 set on manual stop, or on enabled error/early stop.
// [R13] After manual stop, stopped only once mover operations have finished.
// [R14] Bit 4 shows response buffer full, bit 3 response buffer empty.
// [R15] Bit 2 high when either command buffer is full.
// [R16] Bit 1 high only when both command buffers are empty.
// [R17] Bit 0 busy on buffered commands, active movers, or awaited write responses.
// [R18] Interrupt mask gates events before the pending bit latches them.
// [R19] Software reset clears dispatcher and mover registers and FIFOs.
// [R20] Status bits other than interrupt-pending ignore software writes.
module scs_csr_bank #(
    parameter bit ENHANCED_FEATURES = 1'b1,
    parameter logic [31:0] CONFIG_ONE = 32'h0000_0000,
    parameter logic [31:0] CONFIG_TWO = 32'h0000_0000,
    // Arbitrary identity values
    parameter logic [7:0] COMP_TYPE = 8'h5C,
    parameter logic [7:0] COMP_VERSION = 8'h03
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire scs_pkg::scs_csr_req_t csr_req,
    output scs_pkg::scs_csr_rsp_t csr_rsp,
    input wire scs_pkg::scs_engine_obs_t engine_obs,
    output scs_pkg::scs_engine_ctl_t engine_ctl
);
    import scs_pkg::*;

    typedef struct packed {
        logic [CTL_WIDTH-1:0] control;
        logic stopped;
        logic [31:0] readdata;
        logic readdatavalid;
        logic dispatcher_reset;
        logic issue_halt;
        logic irq_pending;
    } scs_bank_state_t;

    scs_bank_state_t st;
    scs_bank_state_t next_st;

    logic [FL_COUNT-1:0] flag_set;
    logic [FL_COUNT-1:0] flag_clear;
    logic [FL_COUNT-1:0] flag_q;
    logic reset_start;
    logic resetting;
    logic movers_active;
    logic hit_status_wr;
    logic hit_control_wr;
    logic [31:0] status_word;

    // Word decode; the two low address bits carry no meaning
    function automatic logic word_hit(input logic [4:0] addr, input logic [4:0] off);
        word_hit = (addr[4:2] == off[4:2]);
    endfunction : word_hit

    // A data bit counts only when its byte lane is enabled
    function automatic logic lane_bit(input logic [3:0] be, input logic [31:0] data,
                                      input int pos);
        lane_bit = data[pos] & be[pos / 8];
    endfunction : lane_bit

    assign hit_status_wr = csr_req.write && word_hit(csr_req.addr, OFF_STATUS);
    assign hit_control_wr = csr_req.write && word_hit(csr_req.addr, OFF_CONTROL);
    assign movers_active = engine_obs.rd_active | engine_obs.wr_active;

    // Reset requests are dropped while a reset cycle runs
    assign reset_start = hit_control_wr && !resetting
        && lane_bit(csr_req.byteenable, csr_req.writedata, CT_RESET); // R19

    always_comb begin
        flag_set = '0;
        flag_clear = '0;
        // Masked events never reach the pending bit
        flag_set[FL_IRQ] = engine_obs.irq_event & st.control[CT_IRQ_MASK]; // R18
        flag_set[FL_ERR] = engine_obs.error_beat & st.control[CT_STOP_ERR]; // R9
        flag_set[FL_EARLY] = engine_obs.early_term & st.control[CT_STOP_EARLY]; // R7
        flag_clear[FL_IRQ] = resetting
            | (hit_status_wr && lane_bit(csr_req.byteenable, csr_req.writedata, ST_IRQ)); // R5
        // Stop causes are left only by a software reset
        flag_clear[FL_ERR] = resetting; // R20
        flag_clear[FL_EARLY] = resetting; // R20
    end

    genvar gi;
    generate
        for (gi = 0; gi < FL_COUNT; gi++) begin : g_flag
            scs_flag_bit u_flag (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .set(flag_set[gi]),
                .clear(flag_clear[gi]),
                .q(flag_q[gi])
            );
        end
    endgenerate

    scs_reset_seq u_reset_seq (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .start(reset_start),
        .drained(engine_obs.fabric_drained),
        .resetting(resetting)
    );

    always_comb begin
        status_word = '0; // R4
        status_word[ST_BUSY] = !(engine_obs.wr_cmd_empty && engine_obs.rd_cmd_empty)
            | movers_active | engine_obs.wr_rsp_wait; // R17
        status_word[ST_CMD_EMPTY] = engine_obs.wr_cmd_empty & engine_obs.rd_cmd_empty; // R16
        status_word[ST_CMD_FULL] = engine_obs.wr_cmd_full | engine_obs.rd_cmd_full; // R15
        status_word[ST_RSP_EMPTY] = engine_obs.rsp_empty; // R14
        status_word[ST_RSP_FULL] = engine_obs.rsp_full; // R14
        status_word[ST_STOPPED] = st.stopped; // R12
        status_word[ST_RESETTING] = resetting; // R10
        status_word[ST_ERR_STOP] = flag_q[FL_ERR]; // R9
        status_word[ST_EARLY_STOP] = flag_q[FL_EARLY]; // R7
        status_word[ST_IRQ] = flag_q[FL_IRQ]; // R5
    end

    always_comb begin
        next_st = st;
        // Control bits; the reset bit is a request and is never stored
        if (resetting) begin
            next_st.control = CTL_RESET_VALUE; // R19
        end else if (hit_control_wr && csr_req.byteenable[0]) begin
            next_st.control = csr_req.writedata[CTL_WIDTH-1:0];
            next_st.control[CT_RESET] = 1'b0;
        end
        // Manual stop waits for mover operations already in progress
        next_st.stopped = (st.control[CT_STOP] && !movers_active) // R13
            | flag_q[FL_ERR] | flag_q[FL_EARLY]; // R12
        if (resetting) begin
            next_st.stopped = 1'b0;
        end
        next_st.readdatavalid = csr_req.read; // R1
        if (csr_req.read) begin
            case (csr_req.addr[4:2])
                OFF_STATUS[4:2]: begin
                    next_st.readdata = status_word;
                end
                OFF_CONTROL[4:2]: begin
                    next_st.readdata = {26'h0, st.control};
                end
                OFF_CMD_FILL[4:2]: begin
                    next_st.readdata = {engine_obs.wr_cmd_fill, engine_obs.rd_cmd_fill}; // R2
                end
                OFF_RSP_FILL[4:2]: begin
                    next_st.readdata = {16'h0, engine_obs.rsp_fill};
                end
                OFF_SEQ_NUM[4:2]: begin
                    // Without the enhanced option the word reads as zero
                    next_st.readdata = ENHANCED_FEATURES
                        ? {engine_obs.wr_seq, engine_obs.rd_seq} : 32'h0000_0000; // R3
                end
                OFF_CONFIG_ONE[4:2]: begin
                    next_st.readdata = CONFIG_ONE;
                end
                OFF_CONFIG_TWO[4:2]: begin
                    next_st.readdata = CONFIG_TWO;
                end
                OFF_IDENTITY[4:2]: begin
                    next_st.readdata = {16'h0, COMP_TYPE, COMP_VERSION};
                end
                default: begin
                    next_st.readdata = 32'h0000_0000;
                end
            endcase
        end
        next_st.dispatcher_reset = resetting | reset_start; // R19
        // Issue stops on any stop cause, a reset, or a full response buffer
        next_st.issue_halt = next_st.control[CT_STOP] | next_st.control[CT_STOP_DESC]
            | next_st.stopped | resetting | reset_start | engine_obs.rsp_full;
        next_st.irq_pending = flag_q[FL_IRQ] | flag_set[FL_IRQ];
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        csr_rsp.readdata = st.readdata;
        csr_rsp.readdatavalid = st.readdatavalid;
        engine_ctl.control = st.control;
        engine_ctl.dispatcher_reset = st.dispatcher_reset;
        engine_ctl.issue_halt = st.issue_halt;
        engine_ctl.irq_pending = st.irq_pending;
    end

    read_latency_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
        csr_req.read |=> csr_rsp.readdatavalid
            ##1 (csr_rsp.readdatavalid == $past(csr_req.read)))
        else $error("read answer not one cycle after request");
    fill_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
        csr_req.read && word_hit(csr_req.addr, OFF_CMD_FILL)
        |=> csr_rsp.readdata == {$past(engine_obs.wr_cmd_fill), $past(engine_obs.rd_cmd_fill)})
        else $error("fill level word mismatch");
    seq_word_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
        csr_req.read && word_hit(csr_req.addr, OFF_SEQ_NUM)
        |=> csr_rsp.readdata == (ENHANCED_FEATURES
            ? {$past(engine_obs.wr_seq), $past(engine_obs.rd_seq)} : 32'h0000_0000))
        else $error("sequence number word wrong");
    irq_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
        flag_q[FL_IRQ] && !resetting
        && !(hit_status_wr && lane_bit(csr_req.byteenable, csr_req.writedata, ST_IRQ))
        |=> flag_q[FL_IRQ])
        else $error("pending bit cleared without a write of one");
    irq_masked_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
        !flag_q[FL_IRQ] && !st.control[CT_IRQ_MASK] |=> !flag_q[FL_IRQ])
        else $error("masked event latched");
    stop_waits_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R13
        movers_active && !flag_q[FL_ERR] && !flag_q[FL_EARLY] |=> !st.stopped)
        else $error("stopped while a mover was active");
    err_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
        flag_q[FL_ERR] && !resetting |=> st.stopped)
        else $error("error stop did not raise stopped");
    status_full_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
        csr_req.read && word_hit(csr_req.addr, OFF_STATUS)
        |=> csr_rsp.readdata[ST_CMD_FULL]
            == $past(engine_obs.wr_cmd_full | engine_obs.rd_cmd_full))
        else $error("descriptor full bit wrong");
    reset_clears_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R19
        resetting |=> st.control == CTL_RESET_VALUE)
        else $error("control survived software reset");

    irq_same_cycle_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        flag_set[FL_IRQ] && flag_clear[FL_IRQ]);
    manual_stop_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        st.control[CT_STOP] && movers_active ##[1:20] st.stopped);
    early_stop_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(flag_q[FL_EARLY]));

endmodule : scs_csr_bank

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import scs_pkg::*;
    localparam logic [31:0] CFG1 = 32'h1357_9BDF;
    localparam logic [31:0] CFG2 = 32'h2468_ACE0;
    // Arbitrary identity values
    localparam logic [7:0] ID_TYPE = 8'h5C;
    localparam logic [7:0] ID_VER = 8'h03;
    localparam int TIME_LIMIT = 2000;
    logic sys_clk;
    logic reset_n;
    scs_csr_req_t csr_req;
    scs_csr_rsp_t csr_rsp;
    scs_engine_obs_t engine_obs;
    scs_engine_ctl_t engine_ctl;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rd;

    scs_csr_bank #(.ENHANCED_FEATURES(1'b1), .CONFIG_ONE(CFG1), .CONFIG_TWO(CFG2),
        .COMP_TYPE(ID_TYPE), .COMP_VERSION(ID_VER)) DUT (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .csr_req(csr_req),
        .csr_rsp(csr_rsp),
        .engine_obs(engine_obs),
        .engine_ctl(engine_ctl)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic csr_read(input logic [4:0] a, output logic [31:0] d);
        csr_req.read = 1'b1;
        csr_req.addr = a;
        step(1);
        csr_req.read = 1'b0;
        for (int i = 0; i < 2 && csr_rsp.readdatavalid !== 1'b1; i++) begin
            step(1);
        end
        check("readdatavalid", 32'h1, {31'h0, csr_rsp.readdatavalid});
        d = csr_rsp.readdata;
        // An edge between reads keeps read from toggling twice in one time step
        step(1);
        check("readdatavalid pulse", 32'h0, {31'h0, csr_rsp.readdatavalid});
    endtask : csr_read

    task automatic csr_write(input logic [4:0] a, input logic [3:0] be, input logic [31:0] d);
        csr_req.write = 1'b1;
        csr_req.addr = a;
        csr_req.byteenable = be;
        csr_req.writedata = d;
        step(1);
        csr_req.write = 1'b0;
    endtask : csr_write

    task automatic stat_case(input logic [6:0] v, input logic [31:0] exp);
        {engine_obs.wr_cmd_empty, engine_obs.rd_cmd_empty, engine_obs.wr_cmd_full,
            engine_obs.rd_cmd_full, engine_obs.rsp_full, engine_obs.rsp_empty,
            engine_obs.wr_rsp_wait} = v;
        step(1);
        csr_read(OFF_STATUS, rd);
        check("status", exp, rd);
    endtask : stat_case

    task automatic t_words;
        engine_obs.wr_cmd_fill = 16'h1234;
        engine_obs.rd_cmd_fill = 16'hABCD;
        engine_obs.rsp_fill = 16'h00F7;
        engine_obs.wr_seq = 16'h0102;
        engine_obs.rd_seq = 16'h0304;
        step(1);
        csr_read(OFF_CMD_FILL, rd);
        check("cmd fill", 32'h1234_ABCD, rd);
        csr_read(OFF_RSP_FILL, rd);
        check("rsp fill", 32'h0000_00F7, rd);
        csr_read(OFF_SEQ_NUM, rd);
        check("sequence", 32'h0102_0304, rd);
        csr_read(OFF_CONFIG_ONE, rd);
        check("config one", CFG1, rd);
        csr_read(OFF_CONFIG_TWO, rd);
        check("config two", CFG2, rd);
        csr_read(OFF_IDENTITY, rd);
        check("identity", {16'h0000, ID_TYPE, ID_VER}, rd);
        $display("test words done");
    endtask : t_words

    task automatic t_status;
        csr_read(OFF_CONTROL, rd);
        check("control at reset", 32'h0000_0000, rd);
        stat_case(7'b0101100, 32'h0000_0015);
        stat_case(7'b1000000, 32'h0000_0001);
        stat_case(7'b1100011, 32'h0000_000B);
        stat_case(7'b1100010, 32'h0000_000A);
        csr_write(OFF_STATUS, 4'hF, 32'hFFFF_FDFF);
        csr_read(OFF_STATUS, rd);
        check("status after write", 32'h0000_000A, rd);
        csr_write(OFF_CONTROL, 4'hF, 32'hFFFF_FFC0);
        csr_read(OFF_CONTROL, rd);
        check("control reserved", 32'h0000_0000, rd);
        $display("test status done");
    endtask : t_status

    task automatic t_irq;
        engine_obs.irq_event = 1'b1;
        step(1);
        engine_obs.irq_event = 1'b0;
        csr_read(OFF_STATUS, rd);
        check("masked irq", 32'h0000_000A, rd);
        csr_write(OFF_CONTROL, 4'h1, 32'h0000_0010);
        engine_obs.irq_event = 1'b1;
        step(1);
        engine_obs.irq_event = 1'b0;
        csr_read(OFF_STATUS, rd);
        check("irq set", 32'h0000_020A, rd);
        check("irq pending out", 32'h1, {31'h0, engine_ctl.irq_pending});
        check("control out", 32'h0000_0010, {26'h0, engine_ctl.control});
        csr_write(OFF_STATUS, 4'hF, 32'h0000_0000);
        csr_read(OFF_STATUS, rd);
        check("irq write zero", 32'h0000_020A, rd);
        engine_obs.irq_event = 1'b1;
        csr_write(OFF_STATUS, 4'hF, 32'h0000_0200);
        engine_obs.irq_event = 1'b0;
        csr_read(OFF_STATUS, rd);
        check("irq set beats clear", 32'h0000_020A, rd);
        csr_write(OFF_STATUS, 4'hF, 32'h0000_0200);
        csr_read(OFF_STATUS, rd);
        check("irq cleared", 32'h0000_000A, rd);
        $display("test irq done");
    endtask : t_irq

    task automatic t_manual;
        engine_obs.rd_active = 1'b1;
        csr_write(OFF_CONTROL, 4'h1, 32'h0000_0001);
        step(2);
        csr_read(OFF_STATUS, rd);
        check("stop in flight", 32'h0000_000B, rd);
        check("issue halt", 32'h1, {31'h0, engine_ctl.issue_halt});
        engine_obs.rd_active = 1'b0;
        step(2);
        csr_read(OFF_STATUS, rd);
        check("stopped", 32'h0000_002A, rd);
        csr_write(OFF_CONTROL, 4'h1, 32'h0000_0000);
        step(2);
        csr_read(OFF_STATUS, rd);
        check("restarted", 32'h0000_000A, rd);
        $display("test manual stop done");
    endtask : t_manual

    task automatic t_faults;
        engine_obs.error_beat = 1'b1;
        engine_obs.early_term = 1'b1;
        step(1);
        engine_obs.error_beat = 1'b0;
        engine_obs.early_term = 1'b0;
        step(1);
        csr_read(OFF_STATUS, rd);
        check("faults disabled", 32'h0000_000A, rd);
        csr_write(OFF_CONTROL, 4'h1, 32'h0000_0004);
        engine_obs.error_beat = 1'b1;
        step(1);
        engine_obs.error_beat = 1'b0;
        step(1);
        csr_read(OFF_STATUS, rd);
        check("error stop", 32'h0000_00AA, rd);
        csr_write(OFF_CONTROL, 4'h1, 32'h0000_000C);
        engine_obs.early_term = 1'b1;
        step(1);
        engine_obs.early_term = 1'b0;
        step(1);
        csr_read(OFF_STATUS, rd);
        check("early stop", 32'h0000_01AA, rd);
        $display("test fault stop done");
    endtask : t_faults

    task automatic t_reset;
        engine_obs.fabric_drained = 1'b0;
        csr_write(OFF_CONTROL, 4'h1, 32'h0000_0002);
        csr_read(OFF_STATUS, rd);
        check("resetting", 32'h1, {31'h0, rd[ST_RESETTING]});
        check("dispatcher reset", 32'h1, {31'h0, engine_ctl.dispatcher_reset});
        csr_write(OFF_CONTROL, 4'h1, 32'h0000_0010);
        step(6);
        csr_read(OFF_STATUS, rd);
        check("resetting held", 32'h1, {31'h0, rd[ST_RESETTING]});
        engine_obs.fabric_drained = 1'b1;
        step(4);
        csr_read(OFF_STATUS, rd);
        check("status after reset", 32'h0000_000A, rd);
        csr_read(OFF_CONTROL, rd);
        check("control after reset", 32'h0000_0000, rd);
        check("dispatcher reset done", 32'h0, {31'h0, engine_ctl.dispatcher_reset});
        $display("test soft reset done");
    endtask : t_reset

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIME_LIMIT) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        reset_n = 1'b0;
        csr_req = '0;
        // Lengths are taken as all ones, so early termination comes only when pulsed
        engine_obs = '0;
        engine_obs.wr_cmd_empty = 1'b1;
        engine_obs.rd_cmd_empty = 1'b1;
        engine_obs.rsp_empty = 1'b1;
        engine_obs.fabric_drained = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        t_status();
        t_words();
        t_irq();
        t_manual();
        t_faults();
        t_reset();
        final_report();
    end
endmodule : tb
